/* logic/dmae_consts.svh */
`ifndef DMAE_CONSTS_SVH
`define DMAE_CONSTS_SVH

// ---------------------------------------------------------------
// register selects on the test-port side
// ---------------------------------------------------------------
`define DMAE_SEL_CTRL     2'h0
`define DMAE_SEL_ADDR     2'h1
`define DMAE_SEL_DATA     2'h2

// ---------------------------------------------------------------
// access_ctrl_status_reg field positions
// ---------------------------------------------------------------
`define DMAE_CS_START     31
`define DMAE_CS_MAP_HI    30
`define DMAE_CS_MAP_LO    28
`define DMAE_CS_PRIO_HI   27
`define DMAE_CS_PRIO_LO   26
`define DMAE_CS_RW        25
`define DMAE_CS_SIZE_HI   24
`define DMAE_CS_SIZE_LO   22
`define DMAE_CS_CNT_HI    21
`define DMAE_CS_CNT_LO    8
`define DMAE_CS_ATTRIBUTE_OVERRIDE_FIELD_HI   7
`define DMAE_CS_ATTRIBUTE_OVERRIDE_FIELD_LO   4
`define DMAE_CS_ERR       1
`define DMAE_CS_DV        0

// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define DMAE_CS_RST       32'h0000_0000
`define DMAE_ADDR_RST     32'h0000_0000
`define DMAE_DATA_RST     64'h0000_0000_0000_0000
`define DMAE_CNT_ONE      14'h0001
`define DMAE_SZ_64        3'h3
`define DMAE_PROT_DEFAULT 6'h03
`define DMAE_ERR_CODE     5'h03
`define DMAE_ERR_TCODE    6'h08
`define DMAE_MSG_LEN      4'hF

`endif

/* logic/dmae_pkg.sv */
package dmae_pkg;

  typedef enum logic [2:0] {
    dmae_st_idle    = 3'b000,
    dmae_st_wait_go = 3'b001,
    dmae_st_arb     = 3'b010,
    dmae_st_xfer    = 3'b011
  } dmae_fsm_t;

  // test-clock side: tool-visible registers and handshake toggles
  typedef struct packed {
    logic [31:0] cs;
    logic [31:0] addr;
    logic [63:0] data;
    logic        ptr;
    logic        rdy;
    logic        cmd_tgl;
    logic        go_tgl;
    logic        done_seen;
    logic [31:0] rdata;
  } dmae_tck_state_t;

  // bus-clock side: working copies and transfer result
  typedef struct packed {
    dmae_fsm_t   fsm;
    logic        cmd_seen;
    logic        go_seen;
    logic        pend_cmd;
    logic        pend_go;
    logic [31:0] nc_cs;
    logic [31:0] nc_addr;
    logic        rw;
    logic [2:0]  size;
    logic [2:0]  map;
    logic [1:0]  prio;
    logic [5:0]  prot;
    logic        gbl;
    logic [31:0] addr;
    logic [13:0] cnt;
    logic [63:0] wdata;
    logic [63:0] rdata;
    logic        res_err;
    logic        res_last;
    logic        res_read;
    logic        done_tgl;
    logic        err_pulse;
  } dmae_bus_state_t;

  typedef struct packed {
    logic        busy;
    logic [3:0]  cnt;
    logic [14:0] sh;
  } dmae_msg_state_t;

endpackage

/* logic/dmae_sync.sv */
`timescale 1ns/1ps
module dmae_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } dmae_sync_state_t;

  dmae_sync_state_t st_reg;
  dmae_sync_state_t st_next;

  // no clock enable here: a frozen synchroniser would hide the enable itself
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d_in;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_out = st_reg.s2;
endmodule

/* logic/dmae_err_msg.sv */
`timescale 1ns/1ps
`include "dmae_consts.svh"
module dmae_err_msg (
  input  wire logic       mclk_in,
  input  wire logic       rstn_in,
  input  wire logic       ce_in,
  input  wire logic       trig_in,
  input  wire logic [3:0] src_id_in,
  output logic            msg_valid_out,
  output logic            msg_data_out
);
  import dmae_pkg::*;

  dmae_msg_state_t st_reg;
  dmae_msg_state_t st_next;

  // a trigger while a message is still going out is dropped
  always_comb begin
    st_next = st_reg;
    if (ce_in) begin
      if (st_reg.busy) begin
        st_next.sh  = {1'b0, st_reg.sh[14:1]};
        st_next.cnt = st_reg.cnt + 4'h1;
        if (st_reg.cnt == (`DMAE_MSG_LEN - 4'h1)) begin
          st_next.busy = 1'b0;
        end
      end else if (trig_in) begin
        st_next.busy = 1'b1;
        st_next.cnt  = 4'h0;
        st_next.sh   = {`DMAE_ERR_CODE, src_id_in, `DMAE_ERR_TCODE};
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign msg_valid_out = st_reg.busy;
  assign msg_data_out  = st_reg.sh[0];
endmodule

/* logic/dmae_top.sv */
`timescale 1ns/1ps
`include "dmae_consts.svh"
// Function
// - each transfer first wins the system bus, then moves the data
// - error-free block step advances address by size, decrements count, asserts ready
// - data-valid flag clears when a block write count reaches zero
// - block transfers run on working copies; visible address and count stay
// - access count zero or one means a single transfer
// - error-free single read loads data, asserts ready, sets data-valid
// - data-valid flag sets on every error-free block read transfer
// - data register is shifted out in 32-bit words, low word first
// - status reaches the tool only through ready, data-valid and error
// - bus error ends the access without retry and clears start
// - bus error sets the error flag
// - bus error emits a 15-bit message: code 00011, source, type 001000
// - bad address or data errors are handled like any bus error
// - control write during a block ends it at the last finished transfer
// - that control write with start set begins the new access
// - that control write with start clear stops the block early
// - bus accesses default to protection 000011 and global low
// - ready holds until capture-DR; low after reset or with debug off
// - error-free single write asserts ready and clears data-valid
module dmae_top (
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  input  wire logic        tck_in,
  input  wire logic        jtag_wr_in,
  input  wire logic        jtag_rd_in,
  input  wire logic [1:0]  jtag_sel_in,
  input  wire logic [31:0] jtag_wdata_in,
  input  wire logic        capture_dr_in,
  input  wire logic        debug_en_in,
  output logic      [31:0] jtag_rdata_out,
  output logic             rdy_n_out,
  input  wire logic        sys_rst_in,
  input  wire logic [3:0]  src_id_in,
  output logic             bus_req_out,
  input  wire logic        bus_gnt_in,
  output logic             bus_valid_out,
  output logic             bus_write_out,
  output logic      [31:0] bus_addr_out,
  output logic      [2:0]  bus_size_out,
  output logic      [1:0]  bus_prio_out,
  output logic      [2:0]  bus_map_out,
  output logic      [5:0]  bus_prot_out,
  output logic             bus_gbl_out,
  output logic      [63:0] bus_wdata_out,
  input  wire logic        bus_done_in,
  input  wire logic        bus_err_in,
  input  wire logic [63:0] bus_rdata_in,
  output logic             err_msg_valid_out,
  output logic             err_msg_data_out
);
  import dmae_pkg::*;

  // ---------------------------------------------------------------
  // state and crossings
  // ---------------------------------------------------------------
  dmae_tck_state_t tr_reg;
  dmae_tck_state_t tr_next;
  dmae_bus_state_t br_reg;
  dmae_bus_state_t br_next;

  logic [1:0] tck_sync;
  logic       ce_t;
  logic       done_s;
  logic [1:0] bus_sync;
  logic       cmd_s;
  logic       go_s;
  logic       sys_rst_s;
  logic [3:0] src_id_s;

  dmae_sync #(.WIDTH(2)) u_sync_tck (
    .clk_in  (tck_in),
    .rstn_in (rstn_in),
    .d_in    ({ce_in, br_reg.done_tgl}),
    .q_out   (tck_sync)
  );
  assign ce_t   = tck_sync[1];
  assign done_s = tck_sync[0];

  dmae_sync #(.WIDTH(2)) u_sync_evt (
    .clk_in  (mclk_in),
    .rstn_in (rstn_in),
    .d_in    ({tr_reg.cmd_tgl, tr_reg.go_tgl}),
    .q_out   (bus_sync)
  );
  assign cmd_s = bus_sync[1];
  assign go_s  = bus_sync[0];

  dmae_sync #(.WIDTH(1)) u_sync_rst (
    .clk_in  (mclk_in),
    .rstn_in (rstn_in),
    .d_in    (sys_rst_in),
    .q_out   (sys_rst_s)
  );

  dmae_sync #(.WIDTH(4)) u_sync_src (
    .clk_in  (mclk_in),
    .rstn_in (rstn_in),
    .d_in    (src_id_in),
    .q_out   (src_id_s)
  );

  // ---------------------------------------------------------------
  // test-clock side: visible registers, flags, ready
  // ---------------------------------------------------------------
  // result fields of br_reg are read here only after the done toggle
  // has crossed, so they have been stable for two test clocks
  always_comb begin
    logic done_ev;
    logic is_64;
    logic unit_end;
    done_ev  = 1'b0;
    is_64    = 1'b0;
    unit_end = 1'b0;
    tr_next  = tr_reg;
    if (ce_t) begin
      done_ev = (done_s != tr_reg.done_seen);
      is_64   = (tr_reg.cs[`DMAE_CS_SIZE_HI:`DMAE_CS_SIZE_LO] == `DMAE_SZ_64);
      tr_next.done_seen = done_s;
      if (capture_dr_in) begin
        tr_next.rdy = 1'b0;
      end
      if (done_ev) begin
        if (br_reg.res_err) begin
          tr_next.cs[`DMAE_CS_ERR]   = 1'b1;
          tr_next.cs[`DMAE_CS_START] = 1'b0;
        end else begin
          tr_next.rdy = 1'b1;
          if (br_reg.res_read) begin
            tr_next.data           = br_reg.rdata;
            tr_next.cs[`DMAE_CS_DV] = 1'b1;
            tr_next.ptr            = 1'b0;
          end else if (br_reg.res_last) begin
            tr_next.cs[`DMAE_CS_DV] = 1'b0;
          end
        end
      end
      if (jtag_wr_in) begin
        case (jtag_sel_in)
          `DMAE_SEL_CTRL: begin
            // a new control word also breaks a running block
            tr_next.cs[31:4]          = jtag_wdata_in[31:4];
            tr_next.cs[`DMAE_CS_ERR]  = done_ev && br_reg.res_err;
            tr_next.cmd_tgl           = ~tr_reg.cmd_tgl;
            tr_next.ptr               = 1'b0;
          end
          `DMAE_SEL_ADDR: begin
            tr_next.addr = jtag_wdata_in;
          end
          `DMAE_SEL_DATA: begin
            if (tr_reg.ptr) begin
              tr_next.data[63:32] = jtag_wdata_in;
            end else begin
              tr_next.data[31:0] = jtag_wdata_in;
            end
            unit_end    = !is_64 || tr_reg.ptr;
            tr_next.ptr = is_64 && !tr_reg.ptr;
            if (unit_end) begin
              tr_next.cs[`DMAE_CS_DV] = 1'b1;
              if (tr_reg.cs[`DMAE_CS_RW]) begin
                tr_next.go_tgl = ~tr_reg.go_tgl;
              end
            end
          end
          default: begin
            tr_next.ptr = tr_reg.ptr;
          end
        endcase
      end else if (jtag_rd_in) begin
        case (jtag_sel_in)
          `DMAE_SEL_CTRL: begin
            tr_next.rdata = tr_reg.cs;
          end
          `DMAE_SEL_ADDR: begin
            tr_next.rdata = tr_reg.addr;
          end
          `DMAE_SEL_DATA: begin
            tr_next.rdata = tr_reg.ptr ? tr_reg.data[63:32] : tr_reg.data[31:0];
            unit_end      = !is_64 || tr_reg.ptr;
            tr_next.ptr   = is_64 && !tr_reg.ptr;
            if (unit_end && !tr_reg.cs[`DMAE_CS_RW]) begin
              tr_next.go_tgl = ~tr_reg.go_tgl;
            end
          end
          default: begin
            tr_next.rdata = 32'h0000_0000;
          end
        endcase
      end
      if (!debug_en_in) begin
        tr_next.rdy = 1'b0;
      end
    end
  end

  always_ff @(posedge tck_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tr_reg      <= '0;
      tr_reg.cs   <= `DMAE_CS_RST;
      tr_reg.addr <= `DMAE_ADDR_RST;
      tr_reg.data <= `DMAE_DATA_RST;
    end else begin
      tr_reg <= tr_next;
    end
  end

  assign jtag_rdata_out = tr_reg.rdata;
  assign rdy_n_out      = ~tr_reg.rdy;

  // ---------------------------------------------------------------
  // bus-clock side: transfer sequencer
  // ---------------------------------------------------------------
  // tr_reg words are sampled only in the cycle a toggle edge is seen;
  // the tool cannot rewrite them within one test clock of the toggle
  always_comb begin
    logic        cmd_ev;
    logic        go_ev;
    logic [31:0] step;
    logic [3:0]  attribute_override_field;
    cmd_ev  = 1'b0;
    go_ev   = 1'b0;
    step    = 32'h0000_0001 << br_reg.size[1:0];
    attribute_override_field    = br_reg.nc_cs[`DMAE_CS_ATTRIBUTE_OVERRIDE_FIELD_HI:`DMAE_CS_ATTRIBUTE_OVERRIDE_FIELD_LO];
    br_next = br_reg;
    br_next.err_pulse = 1'b0;
    if (ce_in) begin
      cmd_ev = (cmd_s != br_reg.cmd_seen);
      go_ev  = (go_s != br_reg.go_seen);
      case (br_reg.fsm)
        dmae_st_idle: begin
          if (br_reg.pend_cmd) begin
            br_next.pend_cmd = 1'b0;
            br_next.pend_go  = 1'b0;
            if (br_reg.nc_cs[`DMAE_CS_START]) begin
              br_next.rw       = br_reg.nc_cs[`DMAE_CS_RW];
              br_next.size     = br_reg.nc_cs[`DMAE_CS_SIZE_HI:`DMAE_CS_SIZE_LO];
              br_next.map      = br_reg.nc_cs[`DMAE_CS_MAP_HI:`DMAE_CS_MAP_LO];
              br_next.prio     = br_reg.nc_cs[`DMAE_CS_PRIO_HI:`DMAE_CS_PRIO_LO];
              br_next.prot     = (`DMAE_PROT_DEFAULT | {2'b00, attribute_override_field[1], attribute_override_field[0], 2'b00})
                                 & ~{4'h0, attribute_override_field[2], 1'b0};
              br_next.gbl      = attribute_override_field[3];
              br_next.addr     = br_reg.nc_addr;
              br_next.cnt      = br_reg.nc_cs[`DMAE_CS_CNT_HI:`DMAE_CS_CNT_LO];
              if (br_reg.nc_cs[`DMAE_CS_CNT_HI:`DMAE_CS_CNT_LO] <= `DMAE_CNT_ONE) begin
                br_next.cnt = `DMAE_CNT_ONE;
              end
              br_next.res_read = !br_reg.nc_cs[`DMAE_CS_RW];
              br_next.fsm      = br_reg.nc_cs[`DMAE_CS_RW] ? dmae_st_wait_go : dmae_st_arb;
            end
          end
        end
        dmae_st_wait_go: begin
          if (br_reg.pend_cmd) begin
            br_next.fsm = dmae_st_idle;
          end else if (br_reg.pend_go) begin
            br_next.pend_go = 1'b0;
            br_next.fsm     = dmae_st_arb;
          end
        end
        dmae_st_arb: begin
          if (!sys_rst_s && bus_gnt_in) begin
            br_next.fsm = dmae_st_xfer;
          end
        end
        dmae_st_xfer: begin
          if (bus_err_in) begin
            // every bus error ends the access, whatever caused it
            br_next.res_err   = 1'b1;
            br_next.res_last  = 1'b1;
            br_next.done_tgl  = ~br_reg.done_tgl;
            br_next.err_pulse = 1'b1;
            br_next.fsm       = dmae_st_idle;
          end else if (bus_done_in) begin
            if (!br_reg.rw) begin
              br_next.rdata = bus_rdata_in;
            end
            br_next.res_err  = 1'b0;
            br_next.addr     = br_reg.addr + step;
            br_next.cnt      = br_reg.cnt - `DMAE_CNT_ONE;
            br_next.res_last = (br_reg.cnt == `DMAE_CNT_ONE);
            br_next.done_tgl = ~br_reg.done_tgl;
            br_next.fsm      = (br_reg.cnt == `DMAE_CNT_ONE) ? dmae_st_idle : dmae_st_wait_go;
          end
        end
        default: begin
          br_next.fsm = dmae_st_idle;
        end
      endcase
      if (cmd_ev) begin
        br_next.cmd_seen = cmd_s;
        br_next.pend_cmd = 1'b1;
        br_next.nc_cs    = tr_reg.cs;
        br_next.nc_addr  = tr_reg.addr;
      end
      if (go_ev) begin
        br_next.go_seen = go_s;
        br_next.pend_go = 1'b1;
        br_next.wdata   = tr_reg.data;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      br_reg      <= '0;
      br_reg.fsm  <= dmae_st_idle;
      br_reg.prot <= `DMAE_PROT_DEFAULT;
    end else begin
      br_reg <= br_next;
    end
  end

  // ---------------------------------------------------------------
  // bus outputs
  // ---------------------------------------------------------------
  assign bus_req_out   = (br_reg.fsm == dmae_st_arb) && !sys_rst_s;
  assign bus_valid_out = (br_reg.fsm == dmae_st_xfer);
  assign bus_write_out = br_reg.rw;
  assign bus_addr_out  = br_reg.addr;
  assign bus_size_out  = br_reg.size;
  assign bus_prio_out  = br_reg.prio;
  assign bus_map_out   = br_reg.map;
  assign bus_prot_out  = br_reg.prot;
  assign bus_gbl_out   = br_reg.gbl;
  assign bus_wdata_out = br_reg.wdata;

  // ---------------------------------------------------------------
  // error message
  // ---------------------------------------------------------------
  dmae_err_msg u_err_msg (
    .mclk_in       (mclk_in),
    .rstn_in       (rstn_in),
    .ce_in         (ce_in),
    .trig_in       (br_reg.err_pulse),
    .src_id_in     (src_id_s),
    .msg_valid_out (err_msg_valid_out),
    .msg_data_out  (err_msg_data_out)
  );
endmodule

/* bench/dmae_top_chk.sv */
`timescale 1ns/1ps
module dmae_top_chk (
  input wire logic        mclk_in,
  input wire logic        rstn_in,
  input wire logic        tck_in,
  input wire logic        debug_en_in,
  input wire logic        rdy_n_out,
  input wire logic        sys_rst_in,
  input wire logic [3:0]  src_id_in,
  input wire logic        bus_req_out,
  input wire logic        bus_gnt_in,
  input wire logic        bus_valid_out,
  input wire logic        bus_write_out,
  input wire logic [31:0] bus_addr_out,
  input wire logic [5:0]  bus_prot_out,
  input wire logic        bus_gbl_out,
  input wire logic        bus_done_in,
  input wire logic        bus_err_in,
  input wire logic        err_msg_valid_out,
  input wire logic        err_msg_data_out
);
  // ----------------------------------------
  // message capture, first bit ends up at bit 0
  // ----------------------------------------
  logic [14:0] msg_reg;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      msg_reg <= 15'h0000;
    end else if (err_msg_valid_out) begin
      msg_reg <= {err_msg_data_out, msg_reg[14:1]};
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_bus_err;
    bus_valid_out && bus_err_in;
  endsequence
  sequence s_msg_frame;
    ##2 err_msg_valid_out [*8] ##1 err_msg_valid_out [*7] ##1 !err_msg_valid_out;
  endsequence
  a_prot_default: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    bus_req_out |-> bus_prot_out == 6'h03 && !bus_gbl_out) else $error("bus attributes not default");
  a_hold_sysrst: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    sys_rst_in [*3] |-> !bus_req_out) else $error("request during system reset");
  a_grant_xfer: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    bus_req_out && bus_gnt_in |=> bus_valid_out) else $error("grant not followed by transfer");
  a_xfer_hold: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    bus_valid_out && !bus_done_in && !bus_err_in |=> bus_valid_out && $stable(bus_addr_out)
    && $stable(bus_write_out)) else $error("transfer dropped or changed");
  a_xfer_end: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    bus_valid_out && (bus_done_in || bus_err_in) |=> !bus_valid_out) else $error("transfer not ended");
  a_no_retry: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    s_bus_err |=> !bus_req_out [*8]) else $error("retry after bus error");
  a_msg_len: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    s_bus_err |-> s_msg_frame) else $error("error message frame length wrong");
  a_msg_bits: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    $fell(err_msg_valid_out) |-> msg_reg == {5'h03, src_id_in, 6'h08}) else $error("error message bits wrong");
  a_rdy_debug: assert property (@(posedge tck_in) disable iff (!rstn_in)
    !debug_en_in |=> rdy_n_out) else $error("ready asserted with debug off");
endmodule

bind dmae_top dmae_top_chk i_chk (
  .mclk_in, .rstn_in, .tck_in, .debug_en_in, .rdy_n_out, .sys_rst_in, .src_id_in, .bus_req_out,
  .bus_gnt_in, .bus_valid_out, .bus_write_out, .bus_addr_out, .bus_prot_out, .bus_gbl_out,
  .bus_done_in, .bus_err_in, .err_msg_valid_out, .err_msg_data_out
);

/* bench/dmae_bus_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// system bus slave, grants and answers after lat_in cycles
// ----------------------------------------
module dmae_bus_model (
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic [3:0]  lat_in,
  input  wire logic [31:0] err_addr_in,
  input  wire logic        req_in,
  input  wire logic        valid_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [63:0] wdata_in,
  output logic             gnt_out,
  output logic             done_out,
  output logic             err_out,
  output logic      [63:0] rdata_out,
  output logic      [31:0] last_addr_out,
  output logic      [63:0] last_wdata_out,
  output logic      [7:0]  xfers_out
);
  logic [3:0] wait_reg;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_reg       <= 4'h0;
      gnt_out        <= 1'b0;
      done_out       <= 1'b0;
      err_out        <= 1'b0;
      rdata_out      <= 64'h0;
      last_addr_out  <= 32'h0;
      last_wdata_out <= 64'h0;
      xfers_out      <= 8'h00;
    end else begin
      gnt_out   <= 1'b0;
      done_out  <= 1'b0;
      err_out   <= 1'b0;
      // idle read lines keep toggling so stale data never looks valid
      rdata_out <= ~rdata_out;
      if ((req_in && !gnt_out) || (valid_in && !done_out && !err_out)) begin
        wait_reg <= wait_reg + 4'h1;
        if (wait_reg == lat_in) begin
          wait_reg <= 4'h0;
          if (!valid_in) begin
            gnt_out <= 1'b1;
          end else if (addr_in == err_addr_in) begin
            err_out <= 1'b1;
          end else begin
            done_out       <= 1'b1;
            rdata_out      <= {~addr_in, addr_in};
            last_addr_out  <= addr_in;
            last_wdata_out <= wdata_in;
            xfers_out      <= xfers_out + 8'h01;
          end
        end
      end
    end
  end
endmodule

/* bench/tb_dmae_top.sv */
`timescale 1ns/1ps
module tb_dmae_top;
  logic        mclk_in = 1'b0, tck_in = 1'b0, rstn_in = 1'b0, ce_in = 1'b1, debug_en_in = 1'b0;
  logic        jtag_wr_in = 1'b0, jtag_rd_in = 1'b0, capture_dr_in = 1'b0, sys_rst_in = 1'b0;
  logic [1:0]  jtag_sel_in = 2'h3;
  logic [31:0] jtag_wdata_in = 32'h0, err_addr = 32'hFFFF_FFF0;
  logic [3:0]  src_id_in = 4'h9, lat = 4'h0;
  logic        rdy_n_out, bus_req_out, bus_gnt_in, bus_valid_out, bus_write_out, bus_gbl_out;
  logic        bus_done_in, bus_err_in, err_msg_valid_out, err_msg_data_out;
  logic [1:0]  bus_prio_out;
  logic [2:0]  bus_size_out, bus_map_out;
  logic [5:0]  bus_prot_out;
  logic [31:0] jtag_rdata_out, bus_addr_out, last_addr, rd;
  logic [63:0] bus_wdata_out, bus_rdata_in, last_wdata;
  logic [7:0]  xfers, n0;
  int          mismatches = 0, tests_run = 0;

  dmae_top i_dut (
    .mclk_in, .rstn_in, .ce_in, .tck_in, .jtag_wr_in, .jtag_rd_in, .jtag_sel_in, .jtag_wdata_in,
    .capture_dr_in, .debug_en_in, .jtag_rdata_out, .rdy_n_out, .sys_rst_in, .src_id_in, .bus_req_out,
    .bus_gnt_in, .bus_valid_out, .bus_write_out, .bus_addr_out, .bus_size_out, .bus_prio_out,
    .bus_map_out, .bus_prot_out, .bus_gbl_out, .bus_wdata_out, .bus_done_in, .bus_err_in,
    .bus_rdata_in, .err_msg_valid_out, .err_msg_data_out
  );
  dmae_bus_model i_bus (
    .mclk_in, .rstn_in, .lat_in(lat), .err_addr_in(err_addr), .req_in(bus_req_out),
    .valid_in(bus_valid_out), .addr_in(bus_addr_out), .wdata_in(bus_wdata_out), .gnt_out(bus_gnt_in),
    .done_out(bus_done_in), .err_out(bus_err_in), .rdata_out(bus_rdata_in), .last_addr_out(last_addr),
    .last_wdata_out(last_wdata), .xfers_out(xfers)
  );

  always #2 mclk_in = ~mclk_in;
  always #15 tck_in = ~tck_in;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic jwr(input logic [1:0] sel, input logic [31:0] val);
    @(posedge tck_in);
    jtag_wr_in    <= 1'b1;
    jtag_sel_in   <= sel;
    jtag_wdata_in <= val;
    @(posedge tck_in);
    jtag_wr_in <= 1'b0;
    repeat (4) @(posedge tck_in);
  endtask

  task automatic jrd(input logic [1:0] sel);
    @(posedge tck_in);
    jtag_rd_in  <= 1'b1;
    jtag_sel_in <= sel;
    @(posedge tck_in);
    jtag_rd_in <= 1'b0;
    @(posedge tck_in);
    @(negedge tck_in);
    rd = jtag_rdata_out;
  endtask

  // waits for ready, then a capture-DR must release it
  task automatic wait_rdy(input logic exp_rdy_n);
    int n;
    n = 0;
    while (rdy_n_out !== 1'b0 && n < 150) begin
      @(posedge tck_in);
      n++;
    end
    check(rdy_n_out, exp_rdy_n);
    if (rdy_n_out === 1'b0) begin
      @(posedge tck_in);
      capture_dr_in <= 1'b1;
      @(posedge tck_in);
      capture_dr_in <= 1'b0;
      @(negedge tck_in);
      check(rdy_n_out, 1'b1);
    end
  endtask

  function automatic logic [31:0] cw(input logic go, input logic wr, input logic [2:0] sz, input logic [13:0] n);
    return {go, 3'h0, 2'h0, wr, sz, n, 8'h00};
  endfunction

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    #200us;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge tck_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge tck_in);
    check(rdy_n_out, 1'b1);
    debug_en_in <= 1'b1;
    jrd(2'h0);
    check(rd, 32'h0);
    for (int s = 0; s < 4; s++) begin
      n0 = xfers;
      jwr(2'h1, 32'h1000 + 32'(s) * 32'h10);
      jwr(2'h0, cw(1'b1, 1'b1, 3'(s), 14'(s % 2)));
      jwr(2'h2, 32'hA5A5_0000 + 32'(s));
      if (s == 3) jwr(2'h2, 32'h5A5A_1234);
      wait_rdy(1'b0);
      check(xfers - n0, 8'h01);
      check(last_addr, 32'h1000 + 32'(s) * 32'h10);
      check(last_wdata & ((64'h1 << (8 << s)) - 64'h1), {32'h5A5A_1234, 32'hA5A5_0000 + 32'(s)}
            & ((64'h1 << (8 << s)) - 64'h1));
      jrd(2'h0);
      check(rd[1:0], 2'b00);
    end
    for (int s = 2; s < 4; s++) begin
      jwr(2'h1, 32'h2000);
      jwr(2'h0, cw(1'b1, 1'b0, 3'(s), 14'h0001));
      wait_rdy(1'b0);
      jrd(2'h0);
      check(rd[0], 1'b1);
      jrd(2'h2);
      check(rd, 32'h2000);
      if (s == 3) jrd(2'h2);
      if (s == 3) check(rd, 32'hFFFF_DFFF);
    end
    lat <= 4'h5;
    n0 = xfers;
    jwr(2'h1, 32'h3000);
    jwr(2'h0, cw(1'b1, 1'b1, 3'h2, 14'h0003));
    for (int k = 0; k < 3; k++) begin
      jwr(2'h2, 32'hC0DE_0000 + 32'(k));
      wait_rdy(1'b0);
      check(last_addr, 32'h3000 + 32'(k) * 4);
      check(last_wdata[31:0], 32'hC0DE_0000 + 32'(k));
    end
    jrd(2'h0);
    check({rd[21:8], rd[0]}, {14'h0003, 1'b0});
    jrd(2'h1);
    check(rd, 32'h3000);
    check(xfers - n0, 8'h03);
    lat <= 4'h0;
    jwr(2'h1, 32'h4000);
    jwr(2'h0, cw(1'b1, 1'b0, 3'h1, 14'h0002));
    for (int k = 0; k < 2; k++) begin
      wait_rdy(1'b0);
      jrd(2'h2);
      check(rd[15:0], 16'h4000 + 16'(k) * 2);
    end
    jrd(2'h0);
    check(rd[0], 1'b1);
    jwr(2'h1, 32'h5000);
    jwr(2'h0, cw(1'b1, 1'b1, 3'h2, 14'h0004));
    jwr(2'h2, 32'h1111_1111);
    wait_rdy(1'b0);
    jwr(2'h0, cw(1'b1, 1'b0, 3'h2, 14'h0001));
    wait_rdy(1'b0);
    jrd(2'h2);
    check(rd, 32'h5000);
    n0 = xfers;
    jwr(2'h0, cw(1'b1, 1'b0, 3'h2, 14'h0004));
    wait_rdy(1'b0);
    jwr(2'h0, cw(1'b0, 1'b0, 3'h2, 14'h0004));
    jrd(2'h2);
    wait_rdy(1'b1);
    check(xfers - n0, 8'h01);
    err_addr <= 32'h8000;
    jwr(2'h1, 32'h8000);
    jwr(2'h0, cw(1'b1, 1'b1, 3'h2, 14'h0001));
    jwr(2'h2, 32'hDEAD_BEEF);
    wait_rdy(1'b1);
    jrd(2'h0);
    check({rd[31], rd[1]}, 2'b01);
    @(posedge tck_in);
    sys_rst_in <= 1'b1;
    n0 = xfers;
    jwr(2'h1, 32'h9000);
    jwr(2'h0, cw(1'b1, 1'b0, 3'h2, 14'h0001));
    repeat (20) @(posedge tck_in);
    check(xfers - n0, 8'h00);
    sys_rst_in <= 1'b0;
    wait_rdy(1'b0);
    jwr(2'h0, cw(1'b1, 1'b0, 3'h2, 14'h0001));
    repeat (20) @(posedge tck_in);
    check(rdy_n_out, 1'b0);
    debug_en_in <= 1'b0;
    repeat (2) @(posedge tck_in);
    check(rdy_n_out, 1'b1);
    tally_and_finish();
  end
endmodule
